// ===== logic/hsc_enable_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1 - mode low: channels shut down independently
// RULE2 - mode high: pairs 1/3 and 2/4 shut together
// RULE3 - mode unconnected: any fault shuts all four
// RULE4 - channel on when two of three inputs set
// RULE5 - supply rise loads second bits from hardware enable
// RULE6 - host writes enables; first bits reset zero
// RULE7 - request comparator drives status bits 3:0
// RULE8 - request bit n maps to channel n+1
// RULE9 - status 5:4 report grouping code, never 11
// RULE10 - protection 00: critical faults only alert
// RULE11 - protection 01: alert and drop power good
// RULE12 - protection 10: alert, drop good, shut group
// RULE13 - force-on works only with key A5 loaded
// RULE14 - keep recording stop-delay samples after shutdown
// RULE15 - readout width register selects 8 or 10 bits
// RULE16 - per-channel extreme clear bits, reset zero
// RULE17 - per-channel extreme freeze bits, reset zero
// RULE18 - delay from qualifying measurement to power good
// RULE19 - deglitch enable registers reset to zero
// RULE20 - store enable register resets to all ones
// RULE21 - synchronise pin inputs before use; hardware enable input is used unsynchronised
module hsc_enable_ctrl #(
   parameter int NCH = 4,
   parameter int PG_UNIT = hsc_pkg::PG_UNIT_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_supply_ok,
   input wire logic i_hardware_enable_input,
   input wire logic i_mode_high,
   input wire logic i_mode_low,
   input wire logic i_prot_high,
   input wire logic i_prot_low,
   input wire logic [3:0] i_on_cmp,
   input wire logic [3:0] i_breaker_trip,
   input wire logic [7:0] i_breaker_flags,
   input wire logic [7:0] i_limit_state,
   input wire logic [3:0] i_undervoltage_warning,
   input wire logic [3:0] i_undervoltage_critical,
   input wire logic [3:0] i_overvoltage_warning,
   input wire logic [3:0] i_overvoltage_critical,
   input wire logic [3:0] i_oc_warning,
   input wire logic [3:0] i_mon_qualified,
   input wire logic i_sample_tick,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output logic [3:0] o_gate_on,
   output logic [3:0] o_power_good_output,
   output logic o_alert,
   output logic [7:0] o_history_record,
   output logic o_history_hi_only,
   output logic [3:0] o_extreme_clear,
   output logic [3:0] o_extreme_freeze,
   output logic [7:0] o_scale_select,
   output logic [7:0] o_trip_ratio,
   output logic [7:0] o_dgl_oc,
   output logic [7:0] o_undervoltage_deglitch_enable,
   output logic [7:0] o_overvoltage_deglitch_enable
);
   // ****************************************************
   // pin synchronisers
   // ****************************************************
   localparam int NPIN = 9;
   logic [NPIN-1:0] pin_raw, pin_s1, pin_s2, pin_s3, pin_stable, next_pin_stable;

   assign pin_raw = {i_supply_ok, i_mode_high, i_mode_low, i_prot_high, i_prot_low, i_on_cmp};
   // a bit moves only once the two later stages agree
   assign next_pin_stable = (pin_stable & (pin_s2 ^ pin_s3)) | (pin_s2 & ~(pin_s2 ^ pin_s3));

   // three-stage capture of asynchronous pins
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
         pin_stable <= '0;
      end else if (i_ce) begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         // RULE21 synchronised pin use
         pin_stable <= next_pin_stable;
      end
   end

   logic supply_ok, supply_prev, supply_rise;
   logic [3:0] on_req;
   logic [1:0] mode_code, prot_code;

   assign supply_ok = pin_stable[8];
   // RULE7 comparator to status
   assign on_req = pin_stable[3:0];
   // both pulled levels seen means a floating pin, same as open
   // RULE9 grouping decode
   assign mode_code = (pin_stable[6] && !pin_stable[7]) ? hsc_pkg::MODE_INDEP :
                      (pin_stable[7] && !pin_stable[6]) ? hsc_pkg::MODE_PAIRED :
                      hsc_pkg::MODE_GROUPED;
   assign prot_code = (pin_stable[4] && !pin_stable[5]) ? hsc_pkg::PROT_SHUT :
                      (pin_stable[5] && !pin_stable[4]) ? hsc_pkg::PROT_PG :
                      hsc_pkg::PROT_ALERT;
   assign supply_rise = supply_ok && !supply_prev;

   // ****************************************************
   // register file
   // ****************************************************
   logic [7:0] scale_sel, store_en, trip_ratio, pg_delay, force_key, force_sel, chan_en;
   logic [7:0] dgl_oc, undervoltage_deglitch_enable, overvoltage_deglitch_enable, read_width, post_stop, ext_clear, ext_freeze;
   logic [7:0] uv_flags, ov_flags, oc_flags, next_chan_en, hw_en_value;

   function automatic logic wr_hit(input logic [7:0] addr);
      wr_hit = i_reg_wr && (i_reg_addr == addr);
   endfunction

   function automatic logic rd_hit(input logic [7:0] addr);
      rd_hit = i_reg_rd && (i_reg_addr == addr);
   endfunction

   // RULE5 hardware enable load value
   assign hw_en_value = i_hardware_enable_input ? hsc_pkg::CHAN_EN_HW_HIGH : hsc_pkg::RST_ZERO;
   // supply rise wins over a host write in the same cycle
   // RULE6 host writes both bits
   assign next_chan_en = supply_rise ? hw_en_value :
                         wr_hit(hsc_pkg::ADDR_CHAN_EN) ? i_reg_wdata : chan_en;

   // plain read/write registers
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scale_sel <= hsc_pkg::RST_ZERO;
         // RULE20 store enable reset
         store_en <= hsc_pkg::RST_STORE_EN;
         trip_ratio <= hsc_pkg::RST_TRIP_RATIO;
         pg_delay <= hsc_pkg::RST_ZERO;
         force_key <= hsc_pkg::RST_ZERO;
         force_sel <= hsc_pkg::RST_ZERO;
         // RULE6 first bits start zero
         chan_en <= hsc_pkg::RST_ZERO;
         // RULE19 deglitch off after reset
         dgl_oc <= hsc_pkg::RST_ZERO;
         undervoltage_deglitch_enable <= hsc_pkg::RST_ZERO;
         overvoltage_deglitch_enable <= hsc_pkg::RST_ZERO;
         read_width <= hsc_pkg::RST_ZERO;
         post_stop <= hsc_pkg::RST_POST_STOP;
         ext_clear <= hsc_pkg::RST_ZERO;
         ext_freeze <= hsc_pkg::RST_ZERO;
         supply_prev <= 1'b0;
      end else if (i_ce) begin
         supply_prev <= supply_ok;
         chan_en <= next_chan_en;
         if (wr_hit(hsc_pkg::ADDR_SCALE_SEL)) scale_sel <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_STORE_EN)) store_en <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_TRIP_RATIO)) trip_ratio <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_PG_DELAY)) pg_delay <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_FORCE_KEY)) force_key <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_FORCE_SEL)) force_sel <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_DGL_OC)) dgl_oc <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_UNDERVOLTAGE_DEGLITCH_ENABLE)) undervoltage_deglitch_enable <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_OVERVOLTAGE_DEGLITCH_ENABLE)) overvoltage_deglitch_enable <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_READ_WIDTH)) read_width <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_POST_STOP)) post_stop <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_EXT_CLEAR)) ext_clear <= i_reg_wdata;
         if (wr_hit(hsc_pkg::ADDR_EXT_FREEZE)) ext_freeze <= i_reg_wdata;
      end
   end

   // ****************************************************
   // fault flags, cleared by reading
   // ****************************************************
   logic [7:0] uv_events, ov_events, oc_events;

   assign uv_events = {i_undervoltage_critical, i_undervoltage_warning};
   assign ov_events = {i_overvoltage_critical, i_overvoltage_warning};
   assign oc_events = {4'h0, i_oc_warning};

   // a new event in the read cycle survives the clear
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         uv_flags <= hsc_pkg::RST_ZERO;
         ov_flags <= hsc_pkg::RST_ZERO;
         oc_flags <= hsc_pkg::RST_ZERO;
      end else if (i_ce) begin
         uv_flags <= (rd_hit(hsc_pkg::ADDR_UV_FLAGS) ? 8'h00 : uv_flags) | uv_events;
         ov_flags <= (rd_hit(hsc_pkg::ADDR_OV_FLAGS) ? 8'h00 : ov_flags) | ov_events;
         oc_flags <= (rd_hit(hsc_pkg::ADDR_OC_FLAGS) ? 8'h00 : oc_flags) | oc_events;
      end
   end

   // ****************************************************
   // enable, force-on and grouped shutdown
   // ****************************************************
   logic [3:0] first_en, second_en, majority, force_on, crit;
   logic [3:0] own_fault, group_fault, shut, next_shut;

   assign first_en = {chan_en[6], chan_en[4], chan_en[2], chan_en[0]};
   assign second_en = {chan_en[7], chan_en[5], chan_en[3], chan_en[1]};
   // RULE4 two-of-three vote
   assign majority = supply_ok ? ((first_en & second_en) | (first_en & on_req) |
                     (second_en & on_req)) : 4'h0;
   // RULE13 key gates force-on
   assign force_on = (force_key == hsc_pkg::FORCE_KEY_VALUE) ? force_sel[3:0] : 4'h0;
   assign crit = i_undervoltage_critical | i_overvoltage_critical;
   // RULE12 critical shuts only under code 10
   assign own_fault = i_breaker_trip | ((prot_code == hsc_pkg::PROT_SHUT) ? crit : 4'h0);
   // RULE1 independent
   // RULE2 pairs 1/3 and 2/4
   // RULE3 all four
   assign group_fault = (mode_code == hsc_pkg::MODE_INDEP) ? own_fault :
                        (mode_code == hsc_pkg::MODE_PAIRED) ?
                        (own_fault | {own_fault[1:0], own_fault[3:2]}) :
                        ((|own_fault) ? 4'hF : 4'h0);
   // a shut channel restarts only after its enable vote drops
   assign next_shut = (shut | group_fault) & majority;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         shut <= 4'h0;
         o_gate_on <= 4'h0;
      end else if (i_ce) begin
         shut <= next_shut;
         o_gate_on <= (majority & ~next_shut) | force_on;
      end
   end

   // ****************************************************
   // power-good delay per channel
   // ****************************************************
   localparam int UW = $clog2(PG_UNIT + 1);
   logic [UW-1:0] unit_cnt;
   logic unit_tick;
   logic [7:0] pg_cnt [NCH];
   logic [3:0] pg_block;
   logic [3:0] next_pg;

   assign unit_tick = (unit_cnt == UW'(PG_UNIT - 1));
   // RULE11 critical drops power good
   assign pg_block = (prot_code != hsc_pkg::PROT_ALERT) ? crit : 4'h0;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         unit_cnt <= '0;
      end else if (i_ce) begin
         unit_cnt <= unit_tick ? '0 : unit_cnt + UW'(1);
      end
   end

   // RULE18 count then assert power good
   for (genvar c = 0; c < NCH; c++) begin : g_pg
      assign next_pg[c] = o_gate_on[c] && i_mon_qualified[c] && !pg_block[c] &&
                          (pg_cnt[c] >= pg_delay);
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            pg_cnt[c] <= 8'h00;
            o_power_good_output[c] <= 1'b0;
         end else if (i_ce) begin
            if (!(o_gate_on[c] && i_mon_qualified[c])) begin
               pg_cnt[c] <= 8'h00;
            end else if (unit_tick && pg_cnt[c] < pg_delay) begin
               pg_cnt[c] <= pg_cnt[c] + 8'h01;
            end
            o_power_good_output[c] <= next_pg[c];
         end
      end
   end

   // ****************************************************
   // history recording after shutdown
   // ****************************************************
   logic [7:0] post_cnt [NCH];
   logic [3:0] rec_stop;
   logic [3:0] gate_prev;

   // RULE14 post-shutdown sample count
   for (genvar c = 0; c < NCH; c++) begin : g_hist
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            post_cnt[c] <= 8'h00;
            rec_stop[c] <= 1'b0;
            gate_prev[c] <= 1'b0;
         end else if (i_ce) begin
            gate_prev[c] <= o_gate_on[c];
            if (o_gate_on[c]) begin
               rec_stop[c] <= 1'b0;
               post_cnt[c] <= 8'h00;
            end else if (gate_prev[c]) begin
               post_cnt[c] <= post_stop;
               rec_stop[c] <= (post_stop == 8'h00);
            end else if (i_sample_tick && post_cnt[c] != 8'h00) begin
               post_cnt[c] <= post_cnt[c] - 8'h01;
               rec_stop[c] <= (post_cnt[c] == 8'h01);
            end
         end
      end
   end

   // ****************************************************
   // output drive and read mux
   // ****************************************************
   logic [7:0] pin_state;
   logic [7:0] retry_state;
   logic [7:0] next_rdata;
   logic next_alert;

   // RULE8 channel n at bit n-1
   assign pin_state = {prot_code, mode_code, on_req};
   // RULE10 warnings and criticals alert
   assign next_alert = |{uv_flags, ov_flags, oc_flags};
   assign retry_state = {3'h0, o_alert, o_power_good_output};

   always_comb begin
      unique case (i_reg_addr)
         hsc_pkg::ADDR_SCALE_SEL: next_rdata = scale_sel;
         hsc_pkg::ADDR_STORE_EN: next_rdata = store_en;
         hsc_pkg::ADDR_TRIP_RATIO: next_rdata = trip_ratio;
         hsc_pkg::ADDR_BREAKER: next_rdata = i_breaker_flags;
         hsc_pkg::ADDR_PIN_STATE: next_rdata = pin_state;
         hsc_pkg::ADDR_LIMIT_STATE: next_rdata = i_limit_state;
         hsc_pkg::ADDR_RETRY_STATE: next_rdata = retry_state;
         hsc_pkg::ADDR_UV_FLAGS: next_rdata = uv_flags;
         hsc_pkg::ADDR_OV_FLAGS: next_rdata = ov_flags;
         hsc_pkg::ADDR_OC_FLAGS: next_rdata = oc_flags;
         hsc_pkg::ADDR_PG_DELAY: next_rdata = pg_delay;
         hsc_pkg::ADDR_FORCE_KEY: next_rdata = force_key;
         hsc_pkg::ADDR_FORCE_SEL: next_rdata = force_sel;
         hsc_pkg::ADDR_CHAN_EN: next_rdata = chan_en;
         hsc_pkg::ADDR_DGL_OC: next_rdata = dgl_oc;
         hsc_pkg::ADDR_UNDERVOLTAGE_DEGLITCH_ENABLE: next_rdata = undervoltage_deglitch_enable;
         hsc_pkg::ADDR_OVERVOLTAGE_DEGLITCH_ENABLE: next_rdata = overvoltage_deglitch_enable;
         hsc_pkg::ADDR_READ_WIDTH: next_rdata = read_width;
         hsc_pkg::ADDR_POST_STOP: next_rdata = post_stop;
         hsc_pkg::ADDR_EXT_CLEAR: next_rdata = ext_clear;
         hsc_pkg::ADDR_EXT_FREEZE: next_rdata = ext_freeze;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_reg_rdata <= 8'h00;
         o_alert <= 1'b0;
      end else if (i_ce) begin
         if (i_reg_rd) o_reg_rdata <= next_rdata;
         o_alert <= next_alert;
      end
   end

   // stores gated per channel once the post-stop count runs out
   assign o_history_record = store_en & {rec_stop, rec_stop} ^ store_en;
   // RULE15 readout width select
   assign o_history_hi_only = read_width[0];
   // RULE16 extreme clear bits
   assign o_extreme_clear = ext_clear[3:0];
   // RULE17 extreme freeze bits
   assign o_extreme_freeze = ext_freeze[3:0];
   assign o_scale_select = scale_sel;
   assign o_trip_ratio = trip_ratio;
   assign o_dgl_oc = dgl_oc;
   assign o_undervoltage_deglitch_enable = undervoltage_deglitch_enable;
   assign o_overvoltage_deglitch_enable = overvoltage_deglitch_enable;

   // ****************************************************
   // checks
   // ****************************************************
   AST_MAJORITY: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE4
      (i_ce && force_on == 4'h0 && shut == 4'h0 && group_fault == 4'h0)
      |=> o_gate_on == $past(majority)) else $error("gate not majority vote");
   AST_HARDWARE_ENABLE_INPUT_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE5
      (i_ce && supply_rise) |=> chan_en == (($past(i_hardware_enable_input)) ? 8'hAA : 8'h00))
      else $error("enable bits not loaded");
   AST_STATUS_ON: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE7
      (i_ce && i_reg_rd && i_reg_addr == 8'h60) |=> o_reg_rdata[3:0] == $past(on_req))
      else $error("request status wrong");
   AST_MODE_CODE: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE9
      mode_code != 2'h3 && prot_code != 2'h3) else $error("illegal code");
   AST_INDEP: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE1
      (mode_code == 2'h2) |-> group_fault == own_fault) else $error("independent leak");
   AST_PAIR: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE2
      (i_ce && mode_code == 2'h1 && own_fault[0] && majority[2] && force_on[2] == 1'b0)
      |=> !o_gate_on[2]) else $error("pair partner stays on");
   AST_GROUP: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE3
      (mode_code == 2'h0 && own_fault != 4'h0) |-> group_fault == 4'hF)
      else $error("group not shut");
   AST_FORCE_KEY: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE13
      (force_key != 8'hA5) |-> force_on == 4'h0) else $error("force without key");
   AST_PG_DROP: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE11
      (i_ce && prot_code == 2'h1 && crit[0]) |=> !o_power_good_output[0])
      else $error("power good kept on critical");
endmodule
`default_nettype wire

// ===== shared/hsc_pkg.sv
package hsc_pkg;
   // ****************************************************
   // register map
   // ****************************************************
   localparam logic [7:0] ADDR_SCALE_SEL = 8'h30;
   localparam logic [7:0] ADDR_STORE_EN = 8'h31;
   localparam logic [7:0] ADDR_TRIP_RATIO = 8'h5E;
   localparam logic [7:0] ADDR_BREAKER = 8'h5F;
   localparam logic [7:0] ADDR_PIN_STATE = 8'h60;
   localparam logic [7:0] ADDR_LIMIT_STATE = 8'h61;
   localparam logic [7:0] ADDR_RETRY_STATE = 8'h62;
   localparam logic [7:0] ADDR_UV_FLAGS = 8'h63;
   localparam logic [7:0] ADDR_OV_FLAGS = 8'h64;
   localparam logic [7:0] ADDR_OC_FLAGS = 8'h65;
   localparam logic [7:0] ADDR_PG_DELAY = 8'h66;
   localparam logic [7:0] ADDR_FORCE_KEY = 8'h67;
   localparam logic [7:0] ADDR_FORCE_SEL = 8'h68;
   localparam logic [7:0] ADDR_CHAN_EN = 8'h69;
   localparam logic [7:0] ADDR_DGL_OC = 8'h6A;
   localparam logic [7:0] ADDR_UNDERVOLTAGE_DEGLITCH_ENABLE = 8'h6B;
   localparam logic [7:0] ADDR_OVERVOLTAGE_DEGLITCH_ENABLE = 8'h6C;
   localparam logic [7:0] ADDR_READ_WIDTH = 8'h6D;
   localparam logic [7:0] ADDR_POST_STOP = 8'h72;
   localparam logic [7:0] ADDR_EXT_CLEAR = 8'h73;
   localparam logic [7:0] ADDR_EXT_FREEZE = 8'h74;

   // ****************************************************
   // reset values and keys
   // ****************************************************
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_STORE_EN = 8'hFF;
   localparam logic [7:0] RST_TRIP_RATIO = 8'hFF;
   localparam logic [7:0] RST_POST_STOP = 8'h19;
   localparam logic [7:0] FORCE_KEY_VALUE = 8'hA5;
   localparam logic [7:0] CHAN_EN_HW_HIGH = 8'hAA;

   // ****************************************************
   // field layout
   // ****************************************************
   localparam int ON_LSB = 0;
   localparam int MODE_LSB = 4;
   localparam int PROT_LSB = 6;
   localparam int CRIT_LSB = 4;
   localparam int ALERT_BIT = 4;

   // ****************************************************
   // decoded three-state codes
   // ****************************************************
   localparam logic [1:0] MODE_GROUPED = 2'h0;
   localparam logic [1:0] MODE_PAIRED = 2'h1;
   localparam logic [1:0] MODE_INDEP = 2'h2;
   localparam logic [1:0] PROT_ALERT = 2'h0;
   localparam logic [1:0] PROT_PG = 2'h1;
   localparam logic [1:0] PROT_SHUT = 2'h2;

   // ****************************************************
   // timing
   // ****************************************************
   localparam int CLK_MHZ = 250;
   localparam int PG_UNIT_US = 1;
   localparam int PG_UNIT_CYCLES = PG_UNIT_US * CLK_MHZ;
endpackage

// ===== verification/hsc_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// three-state pin
// ****************
// level 0 floats, 1 pulls high, 2 pulls low
module hsc_pin_drv (
   input wire logic [1:0] i_level,
   output logic o_high,
   output logic o_low
);
   // a floating pin is seen neither high nor low
   assign o_high = (i_level == 2'h1);
   assign o_low = (i_level == 2'h2);
endmodule
`default_nettype wire

// ===== verification/hsc_enable_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hsc_enable_ctrl_tb;
   // ****************
   // bench signals
   // ****************
   logic clk, rstn, sup, hardware_enable_input, regwr, regrd, mh, ml, ph, pl, alert, hio, ce, tick;
   logic [1:0] mlev, plev;
   logic [3:0] on, trip, crit, wn, f, sh, gate, pg, xclr, xfrz, acc;
   logic [7:0] addr, wd, rdat, brk, lim, en, hrec;
   logic [15:0] rt [14] = '{16'h3000, 16'h31FF, 16'h5EFF, 16'h6600, 16'h6700,
      16'h6800, 16'h6A00, 16'h6B00, 16'h6C00, 16'h6D00, 16'h7219, 16'h7300,
      16'h7400, 16'h2000};
   int num_errors, samples_checked;

   // pin models for the two three-state inputs
   hsc_pin_drv u_mode (.i_level(mlev), .o_high(mh), .o_low(ml));
   hsc_pin_drv u_prot (.i_level(plev), .o_high(ph), .o_low(pl));

   // short power-good unit keeps the run brief
   hsc_enable_ctrl #(.PG_UNIT(4)) dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce),
      .i_supply_ok(sup), .i_hardware_enable_input(hardware_enable_input), .i_mode_high(mh),
      .i_mode_low(ml), .i_prot_high(ph), .i_prot_low(pl), .i_on_cmp(on),
      .i_breaker_trip(trip), .i_breaker_flags(brk), .i_limit_state(lim),
      .i_undervoltage_warning(4'h0), .i_undervoltage_critical(crit),
      .i_overvoltage_warning(wn), .i_overvoltage_critical(4'h0),
      .i_oc_warning(wn), .i_mon_qualified(4'hF), .i_sample_tick(tick),
      .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(regwr), .i_reg_rd(regrd),
      .o_reg_rdata(rdat), .o_gate_on(gate), .o_power_good_output(pg),
      .o_alert(alert), .o_history_record(hrec), .o_history_hi_only(hio),
      .o_extreme_clear(xclr), .o_extreme_freeze(xfrz), .o_scale_select(),
      .o_trip_ratio(), .o_dgl_oc(), .o_undervoltage_deglitch_enable(), .o_overvoltage_deglitch_enable());

   // free-running clock, 4 ns
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   // inputs always move 1 ns after the edge
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wreg(logic [7:0] a, logic [7:0] d);
      addr = a;
      wd = d;
      regwr = 1'b1;
      cyc(1);
      regwr = 1'b0;
      // an idle edge keeps back-to-back strobes apart
      cyc(1);
   endtask

   // read data is registered, so it is looked at one edge later
   task automatic rreg(logic [7:0] a, logic [7:0] e, string n);
      addr = a;
      regrd = 1'b1;
      cyc(1);
      regrd = 1'b0;
      chk(n, e, rdat);
      cyc(1);
   endtask

   function automatic logic [3:0] shut_of(logic [1:0] m, logic [3:0] x);
      if (m == hsc_pkg::MODE_INDEP) return x;
      if (m == hsc_pkg::MODE_PAIRED) return x | {x[1:0], x[3:2]};
      return (x != 4'h0) ? 4'hF : 4'h0;
   endfunction

   function automatic logic [3:0] vote(logic [7:0] e, logic [3:0] o);
      for (int i = 0; i < 4; i++)
         vote[i] = (e[2*i] & e[2*i+1]) | (e[2*i] & o[i]) | (e[2*i+1] & o[i]);
   endfunction

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // watchdog well beyond the expected run length
   initial begin
      #60000;
      num_errors++;
      final_report;
   end

   // main sequence
   initial begin
      {rstn, sup, hardware_enable_input, regwr, regrd, trip, crit, wn, on, mlev, plev, tick, acc} = '0;
      {addr, wd} = '0;
      ce = 1'b1;
      num_errors = 0;
      samples_checked = 0;
      void'($urandom(30839));
      brk = $urandom;
      lim = $urandom;
      cyc(20);
      rstn = 1'b1;
      hardware_enable_input = 1'b1;
      sup = 1'b1;
      cyc(8);
      foreach (rt[i]) rreg(rt[i][15:8], rt[i][7:0], "reset value");
      rreg(8'h5F, brk, "breaker flags");
      rreg(8'h61, lim, "limit state");
      rreg(8'h69, 8'hAA, "enable load");
      $display("test reset done");
      repeat (8) begin
         en = $urandom;
         on = $urandom;
         wn = $urandom;
         acc = acc | wn;
         mlev = 2'($urandom % 3);
         plev = 2'($urandom % 3);
         wreg(8'h69, en);
         cyc(8);
         chk("gate", {4'h0, vote(en, on)}, {4'h0, gate});
         rreg(8'h60, {plev, mlev, on}, "pin state");
         rreg(8'h69, en, "enable bits");
      end
      wn = 4'h0;
      // warnings seen so far must read back and then let alert fall
      rreg(8'h64, {4'h0, acc}, "ov flags");
      rreg(8'h65, {4'h0, acc}, "oc flags");
      cyc(2);
      chk("alert idle", 8'h00, {7'h0, alert});
      $display("test vote done");
      for (int k = 0; k < 9; k++) begin
         mlev = 2'(k % 3);
         plev = 2'(k / 3);
         f = 4'h1 << ($urandom % 4);
         sh = shut_of(mlev, f);
         rreg(8'h63, 8'h00, "clear flags");
         wreg(8'h69, 8'h00);
         wreg(8'h69, 8'hFF);
         trip = f;
         cyc(8);
         trip = 4'h0;
         chk("group shut", {4'h0, ~sh}, {4'h0, gate});
         wreg(8'h69, 8'h00);
         wreg(8'h69, 8'hFF);
         cyc(4);
         crit = f;
         cyc(4);
         chk("crit gate", {4'h0, plev == 2'h2 ? ~sh : 4'hF}, {4'h0, gate});
         chk("crit good", {4'h0, plev == 2'h0 ? 4'hF : ~(plev == 2'h1 ? f : sh)},
            {4'h0, pg});
         chk("alert", 8'h01, {7'h0, alert});
         crit = 4'h0;
         rreg(8'h63, {f, 4'h0}, "uv flags");
      end
      $display("test fault done");
      wreg(8'h69, 8'h00);
      wreg(8'h68, 8'h05);
      cyc(3);
      chk("no key", 8'h00, {4'h0, gate});
      wreg(8'h67, 8'hA5);
      wreg(8'h6D, 8'h01);
      wreg(8'h73, 8'h09);
      wreg(8'h74, 8'h06);
      cyc(3);
      chk("forced", 8'h05, {4'h0, gate});
      chk("hi only", 8'h01, {7'h0, hio});
      chk("clear", 8'h09, {4'h0, xclr});
      chk("freeze", 8'h06, {4'h0, xfrz});
      // a write while the clock enable is low must be lost
      ce = 1'b0;
      wreg(8'h66, 8'h12);
      ce = 1'b1;
      rreg(8'h66, 8'h00, "frozen write");
      // forced channels 1 and 3 drop, then two samples end their recording
      wreg(8'h72, 8'h02);
      wreg(8'h68, 8'h00);
      cyc(1);
      tick = 1'b1;
      cyc(2);
      tick = 1'b0;
      chk("record", 8'hAA, hrec);
      $display("test control done");
      final_report;
   end
endmodule
`default_nettype wire
